// File: logic/cfg_regs_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CFG_REGS_MAP_SVH
`define CFG_REGS_MAP_SVH
// Operation
// - A disabled first pin floats whatever the interrupt does; the enable bit turns it on.
// - Drive bit 1 clear drives the first pin always; set drives it only while asserted.
// - Polarity bit 0 picks active high at 0 and active low at 1 on the first pin.
// - The queue interrupt rises while the stored word count exceeds bits 13:8.
// - The queue interrupt falls by itself once the count is at or below the threshold.
// - A new slave address is taken only when the same write puts the key in the top byte.
// - The 7-bit slave address sits in bits 7:1 with reset 0x64 and bit 0 reads zero.
// - With calibration enabled, fast cycles over two slow periods land in a 12-bit field.
// - Second pin code 0x00 is legacy, 0x01 the masked interrupt, 0x02 the slot window.
// - The queue interrupt passes only while mask bit 8 is 0, and the mask resets to 1.

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define IDX_IRQ_MASK      9'h001
`define IDX_PIN_CFG       9'h002
`define IDX_QUEUE_FILL_THRESHOLD   9'h006
`define IDX_CHIP_ID       9'h008
`define IDX_SLAVE_ADDR    9'h009
`define IDX_FAST_SLOW_CYCLE_COUNT     9'h00A
`define IDX_ALT_FUNC      9'h00B
`define IDX_EVT_STATUS    9'h010
`define IDX_EVT_CLEAR     9'h011
`define IDX_EVT_ENABLE    9'h012
`define IDX_CAL_CTRL      9'h050

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define POS_FIFO_MASK     8
`define POS_PIN_EN        2
`define POS_PIN_DRV       1
`define POS_PIN_POL       0
`define POS_CAL_EN        5
`define ADDR_KEY          8'hAD
`define ADDR_RESET        7'h64
`define MASK_RESET        1'b1
`define ALT_LEGACY        5'h00
`define ALT_MASKED_IRQ    5'h01
`define ALT_SLOT_WINDOW   5'h02
`define EVT_BITS          3
`define CLK_HZ            10000000
`endif

// File: logic/cfg_regs_pkg.sv
// Types shared by the configuration register block
package cfg_regs_pkg;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [10:0] address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avs_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } avs_rsp_t;

  typedef struct packed {
    logic value;
    logic oe;
  } pin_drive_t;

  typedef enum logic [1:0] {
    RATIO_IDLE,
    RATIO_ARM,
    RATIO_COUNT
  } ratio_state_t;

endpackage

// File: logic/clock_ratio_counter.sv
// Counts system clock cycles across two slow clock periods
`timescale 1ns/1ps
module clock_ratio_counter
  import cfg_regs_pkg::*;
#(
  parameter int W = 12
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic         i_enable,
  input  wire logic         i_slow_rise,
  output logic [W-1:0]      o_result,
  output logic              o_done
);
  ratio_state_t   state_reg;
  logic [W-1:0]   count_reg;
  logic           second_reg;
  wire            at_max = &count_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg  <= RATIO_IDLE;
      count_reg  <= '0;
      second_reg <= 1'b0;
      o_result   <= '0;
      o_done     <= 1'b0;
    end else begin
      o_done <= 1'b0;
      unique case (state_reg)
        RATIO_IDLE: if (i_enable) state_reg <= RATIO_ARM;
        RATIO_ARM: begin
          count_reg  <= '0;
          second_reg <= 1'b0;
          if (!i_enable) state_reg <= RATIO_IDLE;
          else if (i_slow_rise) state_reg <= RATIO_COUNT;
        end
        RATIO_COUNT: begin
          // Saturates rather than wrapping on a stalled slow clock
          if (!at_max) count_reg <= count_reg + 1'b1;
          if (!i_enable) begin
            state_reg <= RATIO_IDLE;
          end else if (i_slow_rise && second_reg) begin
            // The cycle of the closing rise belongs to the span as well
            o_result  <= at_max ? count_reg : count_reg + 1'b1;
            o_done    <= 1'b1;
            state_reg <= RATIO_ARM;
          end else if (i_slow_rise) begin
            second_reg <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule

// File: logic/gpio_irq_fifo_config_regs.sv
// Pin, queue interrupt, identity, address and clock ratio registers
`timescale 1ns/1ps
`include "cfg_regs_map.svh"
module gpio_irq_fifo_config_regs #(
  parameter int         CNT_W       = 8,
  parameter logic [7:0] REVISION    = 8'h5A,  // Arbitrary identity value
  parameter logic [7:0] PART_ID     = 8'h3C   // Arbitrary identity value
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rstn,
  input  wire cfg_regs_pkg::avs_req_t   i_avs_req,
  output cfg_regs_pkg::avs_rsp_t        o_avs_rsp,
  input  wire logic [CNT_W-1:0]         i_fifo_word_count,
  input  wire logic                     i_slot_first_start,
  input  wire logic                     i_slot_last_end,
  input  wire logic                     i_legacy_signal,
  input  wire logic                     i_slow_clk,
  output cfg_regs_pkg::pin_drive_t      o_first_aux_pin,
  output logic                          o_second_aux_pin,
  output logic [6:0]                    o_slave_address,
  output logic                          o_irq
);
  import cfg_regs_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [5:0]           thresh_reg;
  logic                 mask_reg;
  logic                 pin_en_reg;
  logic                 pin_drv_reg;
  logic                 pin_pol_reg;
  logic [4:0]           alt_reg;
  logic                 cal_en_reg;
  logic [`EVT_BITS-1:0] evt_stat_reg;
  logic [`EVT_BITS-1:0] evt_en_reg;
  logic                 window_reg;
  logic                 fwd_prev_reg;
  logic [11:0]          ratio;
  logic                 ratio_done;
  logic                 slow_level;
  logic                 slow_rise;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire [8:0]  idx      = i_avs_req.address[10:2];
  wire        req      = i_avs_req.read | i_avs_req.write;
  wire        wr_go    = i_avs_req.write & ~o_avs_rsp.waitrequest;
  wire        rd_load  = req & o_avs_rsp.waitrequest;
  wire        be_lo    = i_avs_req.byteenable[0];
  wire        be_hi    = i_avs_req.byteenable[1];
  wire [15:0] wd       = i_avs_req.writedata[15:0];

  wire        hit_mask   = (idx == `IDX_IRQ_MASK);
  wire        hit_pin    = (idx == `IDX_PIN_CFG);
  wire        hit_thresh = (idx == `IDX_QUEUE_FILL_THRESHOLD);
  wire        hit_id     = (idx == `IDX_CHIP_ID);
  wire        hit_addr   = (idx == `IDX_SLAVE_ADDR);
  wire        hit_ratio  = (idx == `IDX_FAST_SLOW_CYCLE_COUNT);
  wire        hit_alt    = (idx == `IDX_ALT_FUNC);
  wire        hit_stat   = (idx == `IDX_EVT_STATUS);
  wire        hit_clr    = (idx == `IDX_EVT_CLEAR);
  wire        hit_en     = (idx == `IDX_EVT_ENABLE);
  wire        hit_cal    = (idx == `IDX_CAL_CTRL);

  wire        wr_lo    = wr_go & be_lo;
  wire        wr_hi    = wr_go & be_hi;

  // Key check: both lanes must be written so key and address arrive together
  // keyed address write
  wire        addr_ok  = wr_lo & wr_hi & hit_addr & (wd[15:8] == `ADDR_KEY);

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  wire [15:0] rd_mask   = {7'h00, mask_reg, 8'h00};
  wire [15:0] rd_pin    = {13'h0000, pin_en_reg, pin_drv_reg, pin_pol_reg};
  wire [15:0] rd_thresh = {2'h0, thresh_reg, 8'h00};
  wire [15:0] rd_id     = {REVISION, PART_ID};
  wire [15:0] rd_addr   = {8'h00, o_slave_address, 1'b0};
  wire [15:0] rd_ratio  = {4'h0, ratio};
  wire [15:0] rd_alt    = {3'h0, alt_reg, 8'h00};
  wire [15:0] rd_stat   = {13'h0000, evt_stat_reg};
  wire [15:0] rd_en     = {13'h0000, evt_en_reg};
  wire [15:0] rd_cal    = {10'h000, cal_en_reg, 5'h00};

  // Unmapped indices and the clear register read as zero
  wire [15:0] rd_word =
      ({16{hit_mask}}   & rd_mask)   |
      ({16{hit_pin}}    & rd_pin)    |
      ({16{hit_thresh}} & rd_thresh) |
      ({16{hit_id}}     & rd_id)     |
      ({16{hit_addr}}   & rd_addr)   |
      ({16{hit_ratio}}  & rd_ratio)  |
      ({16{hit_alt}}    & rd_alt)    |
      ({16{hit_stat}}   & rd_stat)   |
      ({16{hit_en}}     & rd_en)     |
      ({16{hit_cal}}    & rd_cal);

  // ----------------------------------------
  // Queue interrupt and pin signals
  // ----------------------------------------
  // count above threshold
  wire fifo_level = ({2'b00, i_fifo_word_count} > {{(CNT_W + 2 - 6){1'b0}}, thresh_reg});

  wire fifo_fwd   = fifo_level & ~mask_reg;

  // Second pin drive and polarity are not configurable here; it drives high-true
  // second pin function select
  wire pin2_sel =
      (alt_reg == `ALT_LEGACY)      ? i_legacy_signal :
      (alt_reg == `ALT_MASKED_IRQ)  ? fifo_fwd :
      (alt_reg == `ALT_SLOT_WINDOW) ? window_reg : 1'b0;

  wire pin1_value = fifo_fwd ^ pin_pol_reg;

  // open drain drives only when asserted
  wire pin1_oe    = pin_en_reg & (~pin_drv_reg | fifo_fwd);

  wire [`EVT_BITS-1:0] evt_set = {addr_ok, ratio_done, fifo_fwd & ~fwd_prev_reg};
  wire [`EVT_BITS-1:0] evt_clr = (wr_lo & hit_clr) ? wd[`EVT_BITS-1:0] : '0;

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  pin_sync3 u_slow_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_pin   (i_slow_clk),
    .o_level (slow_level),
    .o_rise  (slow_rise)
  );

  clock_ratio_counter #(
    .W (12)
  ) u_ratio (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_enable    (cal_en_reg),
    .i_slow_rise (slow_rise),
    .o_result    (ratio),
    .o_done      (ratio_done)
  );

  // ----------------------------------------
  // Bus answer: one wait cycle, then data with waitrequest low
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_avs_rsp.waitrequest <= 1'b1;
      o_avs_rsp.readdata    <= 32'h0000_0000;
    end else begin
      o_avs_rsp.waitrequest <= ~rd_load;
      if (rd_load) o_avs_rsp.readdata <= {16'h0000, rd_word};
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      mask_reg    <= `MASK_RESET;
      thresh_reg  <= 6'h00;
      pin_en_reg  <= 1'b0;
      pin_drv_reg <= 1'b0;
      pin_pol_reg <= 1'b0;
      alt_reg     <= 5'h00;
      cal_en_reg  <= 1'b0;
      evt_en_reg  <= '0;
    end else begin
      if (wr_hi && hit_mask)   mask_reg   <= wd[`POS_FIFO_MASK];
      if (wr_hi && hit_thresh) thresh_reg <= wd[13:8];
      if (wr_hi && hit_alt)    alt_reg    <= wd[12:8];
      if (wr_lo && hit_cal)    cal_en_reg <= wd[`POS_CAL_EN];
      if (wr_lo && hit_en)     evt_en_reg <= wd[`EVT_BITS-1:0];
      if (wr_lo && hit_pin) begin
        pin_en_reg  <= wd[`POS_PIN_EN];
        pin_drv_reg <= wd[`POS_PIN_DRV];
        pin_pol_reg <= wd[`POS_PIN_POL];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_slave_address <= `ADDR_RESET;
    end else if (addr_ok) begin
      o_slave_address <= wd[7:1];
    end
  end

  // ----------------------------------------
  // Events and interrupt output
  // ----------------------------------------
  // A set in the same cycle as its clear wins, so no event is lost
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      evt_stat_reg <= '0;
      fwd_prev_reg <= 1'b0;
      o_irq        <= 1'b0;
    end else begin
      evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_set;
      fwd_prev_reg <= fifo_fwd;
      o_irq        <= |(evt_stat_reg & evt_en_reg);
    end
  end

  // ----------------------------------------
  // Slot window and pin outputs
  // ----------------------------------------
  // window from first slot start to last slot end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      window_reg <= 1'b0;
    end else if (i_slot_first_start) begin
      window_reg <= 1'b1;
    end else if (i_slot_last_end) begin
      window_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_first_aux_pin.value <= 1'b0;
      o_first_aux_pin.oe    <= 1'b0;
      o_second_aux_pin      <= 1'b0;
    end else begin
      o_first_aux_pin.value <= pin1_value;
      o_first_aux_pin.oe    <= pin1_oe;
      o_second_aux_pin      <= pin2_sel;
    end
  end

endmodule

// File: logic/pin_sync3.sv
// Three-stage input synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module pin_sync3 (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Only s2 and s3 are compared; s1 may be metastable
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      o_level <= 1'b0;
      o_rise  <= 1'b0;
    end else begin
      s1_reg  <= i_pin;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      if (s2_reg == s3_reg) o_level <= s3_reg;
      o_rise  <= (s2_reg == s3_reg) && s3_reg && !o_level;
    end
  end
endmodule

// File: tb/avs_host_model.sv
// Register bus master standing in for the host processor
`timescale 1ns/1ps
module avs_host_model (
  input  wire logic                   i_clk,
  input  wire cfg_regs_pkg::avs_rsp_t i_rsp,
  output cfg_regs_pkg::avs_req_t      o_req
);
  import cfg_regs_pkg::*;
  initial o_req = '0;
  task automatic xfer(input logic wr, input logic [8:0] idx, input logic [15:0] d,
                      input logic [3:0] be, output logic [15:0] q);
    o_req <= '{read: !wr, write: wr, address: {idx, 2'b00}, byteenable: be,
               writedata: {16'h0000, d}};
    do @(posedge i_clk); while (i_rsp.waitrequest !== 1'b0);
    q = i_rsp.readdata[15:0];
    o_req <= '0;
    @(posedge i_clk);
  endtask
endmodule

// File: tb/cfg_regs_monitor.sv
// Bus, reset and first pin checks for the configuration register block
`timescale 1ns/1ps
`include "cfg_regs_map.svh"
module cfg_regs_monitor
  import cfg_regs_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic                   i_clk,
  input wire logic                   i_rstn,
  input wire cfg_regs_pkg::avs_req_t i_avs_req,
  input wire cfg_regs_pkg::avs_rsp_t o_avs_rsp,
  input wire logic [CNT_W-1:0]       i_fifo_word_count,
  input wire cfg_regs_pkg::pin_drive_t o_first_aux_pin,
  input wire logic [6:0]             o_slave_address
);
  // ----
  // Shadow of the pin settings, trusted once three cycles old
  // ----
  wire        acc = i_avs_req.write && !o_avs_rsp.waitrequest;
  wire [8:0]  idx = i_avs_req.address[10:2];
  wire [15:0] wd  = i_avs_req.writedata[15:0];
  wire [3:0]  be  = i_avs_req.byteenable;
  wire        key_wr = acc && idx == `IDX_SLAVE_ADDR && be[1:0] == 2'b11 && wd[15:8] == `ADDR_KEY;
  logic [2:0] cfg_reg;
  logic [5:0] thr_reg;
  logic       mask_reg;
  logic [1:0] age_reg;
  wire        settled = age_reg == 2'd3;
  wire        lvl = (i_fifo_word_count > CNT_W'(thr_reg)) && !mask_reg;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cfg_reg  <= '0;
      thr_reg  <= '0;
      mask_reg <= `MASK_RESET;
      age_reg  <= '0;
    end else begin
      age_reg <= acc ? 2'd0 : (settled ? age_reg : age_reg + 2'd1);
      if (acc && be[0] && idx == `IDX_PIN_CFG) cfg_reg <= wd[2:0];
      if (acc && be[1] && idx == `IDX_QUEUE_FILL_THRESHOLD) thr_reg <= wd[13:8];
      if (acc && be[1] && idx == `IDX_IRQ_MASK) mask_reg <= wd[`POS_FIFO_MASK];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_wait_answer: assert property ((i_avs_req.read || i_avs_req.write) && o_avs_rsp.waitrequest
    |=> !o_avs_rsp.waitrequest) else $error("bus answer late");
  a_wait_single: assert property (!o_avs_rsp.waitrequest |=> o_avs_rsp.waitrequest)
    else $error("bus answer too long");
  a_wait_idle: assert property (!(i_avs_req.read || i_avs_req.write) && o_avs_rsp.waitrequest
    |=> o_avs_rsp.waitrequest) else $error("answer without request");
  a_reset_values: assert property ($rose(i_rstn) |-> o_avs_rsp.waitrequest &&
    !o_first_aux_pin.oe && o_slave_address == `ADDR_RESET) else $error("bad reset state");
  a_pin_float: assert property (settled && !cfg_reg[2] |-> !o_first_aux_pin.oe)
    else $error("disabled pin driven");
  a_drive_always: assert property (settled && cfg_reg[2:1] == 2'b10 |-> o_first_aux_pin.oe)
    else $error("push-pull pin released");
  a_open_drain: assert property (settled && cfg_reg[2:1] == 2'b11 |->
    o_first_aux_pin.oe == (o_first_aux_pin.value ^ cfg_reg[0])) else $error("open drain wrong");
  a_pin_level: assert property (settled |->
    o_first_aux_pin.value == ($past(lvl) ^ cfg_reg[0])) else $error("pin level wrong");
  a_addr_keyed: assert property ($past(i_rstn) && $changed(o_slave_address) |->
    $past(key_wr) || $past(key_wr, 2)) else $error("address changed without key");
  cover property (key_wr);
  cover property (settled && cfg_reg[2:1] == 2'b11 && o_first_aux_pin.oe);
  cover property ($rose(o_first_aux_pin.value));
endmodule
bind gpio_irq_fifo_config_regs cfg_regs_monitor #(.CNT_W(CNT_W)) mon (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_avs_req(i_avs_req), .o_avs_rsp(o_avs_rsp),
  .i_fifo_word_count(i_fifo_word_count), .o_first_aux_pin(o_first_aux_pin),
  .o_slave_address(o_slave_address));

// File: tb/gpio_irq_fifo_config_regs_test.sv
// Self-checking bench for the configuration register block
`timescale 1ns/1ps
`include "cfg_regs_map.svh"
module gpio_irq_fifo_config_regs_test;
  import cfg_regs_pkg::*;
  localparam logic [7:0] REV = 8'h21;  // Arbitrary identity value
  localparam logic [7:0] PID = 8'h47;  // Arbitrary identity value
  localparam logic [15:0] RATIO_EXP = 16'h0258;  // Two slow periods of 300 cycles each
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  avs_req_t    req;
  avs_rsp_t    rsp;
  logic [7:0]  cnt = 8'h00;
  logic        s_start = 1'b0, s_end = 1'b0, legacy = 1'b0, slow = 1'b0;
  pin_drive_t  pin;
  logic        pin2, irq;
  logic [6:0]  saddr;
  logic [15:0] q;
  int          err_total = 0, checks_done = 0;
  // Board pull-up holds a released pin high
  wire         pin_wire = pin.oe ? pin.value : 1'b1;
  gpio_irq_fifo_config_regs #(.CNT_W(8), .REVISION(REV), .PART_ID(PID)) uut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_avs_req(req), .o_avs_rsp(rsp),
    .i_fifo_word_count(cnt), .i_slot_first_start(s_start), .i_slot_last_end(s_end),
    .i_legacy_signal(legacy), .i_slow_clk(slow), .o_first_aux_pin(pin),
    .o_second_aux_pin(pin2), .o_slave_address(saddr), .o_irq(irq));
  avs_host_model host (.i_clk(i_clk), .i_rsp(rsp), .o_req(req));
  initial forever #50 i_clk = ~i_clk;
  always begin
    repeat (150) @(posedge i_clk);
    slow <= ~slow;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rd(input logic [8:0] a);
    host.xfer(1'b0, a, 16'h0000, 4'hF, q);
  endtask
  task automatic t_regs();
    logic [8:0]  ia [6] = '{`IDX_IRQ_MASK, `IDX_QUEUE_FILL_THRESHOLD, `IDX_CHIP_ID, `IDX_SLAVE_ADDR,
                            `IDX_FAST_SLOW_CYCLE_COUNT, 9'h003};
    logic [15:0] ea [6] = '{16'h0100, 16'h0000, {REV, PID}, 16'h00C8, 16'h0000, 16'h0000};
    foreach (ia[i]) begin
      rd(ia[i]);
      chk(q, ea[i], "reset value");
    end
    wr(`IDX_CHIP_ID, 16'hFFFF);
    wr(9'h003, 16'hFFFF);
    rd(`IDX_CHIP_ID);
    chk(q, {REV, PID}, "id overwritten");
    rd(9'h003);
    chk(q, 16'h0000, "unmapped readback");
  endtask
  task automatic t_queue();
    wr(`IDX_IRQ_MASK, 16'h0000);
    wr(`IDX_QUEUE_FILL_THRESHOLD, 16'h0500);
    wr(`IDX_PIN_CFG, 16'h0004);
    for (int c = 4; c <= 7; c++) begin
      cnt <= c[7:0];
      tick(3);
      chk(pin.value, c > 5, "threshold compare");
      chk(pin.oe, 1'b1, "push-pull drive");
    end
    wr(`IDX_PIN_CFG, 16'h0007);
    cnt <= 8'h05;
    tick(3);
    chk({pin.oe, pin_wire}, 2'b01, "open drain idle");
    cnt <= 8'h06;
    tick(3);
    chk({pin.oe, pin_wire}, 2'b10, "open drain active low");
    wr(`IDX_PIN_CFG, 16'h0003);
    tick(3);
    chk(pin.oe, 1'b0, "disabled pin");
    wr(`IDX_IRQ_MASK, 16'h0100);
    wr(`IDX_PIN_CFG, 16'h0004);
    tick(3);
    chk(pin.value, 1'b0, "masked queue level");
    rd(`IDX_EVT_STATUS);
    chk(q[0], 1'b1, "queue rise event");
  endtask
  task automatic t_addr();
    wr(`IDX_EVT_ENABLE, 16'h0004);
    wr(`IDX_SLAVE_ADDR, 16'h0025);
    host.xfer(1'b1, `IDX_SLAVE_ADDR, 16'hAD25, 4'h1, q);
    tick(2);
    chk(saddr, 7'h64, "address without key");
    chk(irq, 1'b0, "no address event");
    wr(`IDX_SLAVE_ADDR, 16'hAD25);
    tick(2);
    chk(saddr, 7'h12, "keyed address");
    rd(`IDX_SLAVE_ADDR);
    chk(q, 16'h0024, "address readback");
    chk(irq, 1'b1, "address event");
    wr(`IDX_EVT_ENABLE, 16'h0000);
    tick(2);
    chk(irq, 1'b0, "event disabled");
    wr(`IDX_EVT_CLEAR, 16'h0004);
    rd(`IDX_EVT_STATUS);
    chk(q[2], 1'b0, "event cleared");
  endtask
  task automatic t_ratio();
    int n = 0;
    wr(`IDX_EVT_ENABLE, 16'h0002);
    wr(`IDX_CAL_CTRL, 16'h0020);
    while (irq !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    chk(irq, 1'b1, "ratio done event");
    rd(`IDX_FAST_SLOW_CYCLE_COUNT);
    chk(q, RATIO_EXP, "two slow periods");
    wr(`IDX_CAL_CTRL, 16'h0000);
  endtask
  task automatic t_second();
    legacy <= 1'b1;
    tick(3);
    chk(pin2, 1'b1, "legacy code");
    wr(`IDX_ALT_FUNC, 16'h0100);
    tick(2);
    chk(pin2, 1'b0, "masked irq code");
    wr(`IDX_IRQ_MASK, 16'h0000);
    tick(2);
    chk(pin2, 1'b1, "unmasked irq code");
    wr(`IDX_IRQ_MASK, 16'h0100);
    wr(`IDX_ALT_FUNC, 16'h0200);
    s_start <= 1'b1;
    tick(1);
    s_start <= 1'b0;
    tick(3);
    chk(pin2, 1'b1, "slot window open");
    s_end <= 1'b1;
    tick(1);
    s_end <= 1'b0;
    tick(3);
    chk(pin2, 1'b0, "slot window closed");
    wr(`IDX_ALT_FUNC, 16'h0300);
    tick(2);
    chk(pin2, 1'b0, "unsupported code");
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    tick(20000);
    err_total++;
    report_and_stop();
  end
  initial begin
    tick(2);
    i_rstn <= 1'b1;
    tick(1);
    t_regs();
    t_queue();
    t_addr();
    t_ratio();
    t_second();
    report_and_stop();
  end
endmodule
